// ---- rec_defs.svh ----
// register map, field positions, reset values and timing counts for the regulator enable block
// Operation
// - a set boost pin-select bit lets the same-numbered control pin switch buck-boost
// - boost pin selection counts only while boost sequence is 111 and enable is 10
// - several selected boost pins combine by logical OR into the buck-boost enable
// - boost pin-select mask resets to control pin 3 selected, all others clear
// - linreg1 sequence 000 keeps it off; 001 turns it on when supply present
// - sequence 010, 011, 100 turn linreg1 on at 0, 25, 50 percent of boot
// - sequence 111 hands linreg1 to its enable field after full boot; 101, 110 reserved
// - linreg1 enable field only acts while its sequence field holds 111
// - enable field 00 off, 01 on, 10 pin-controlled, 11 reserved
// - internal supply bit set ties linreg1 input to core supply through resistor
// - active discharge in hard reset, and when set, also after enable falls low
// - linreg1 load-switch mode bit is latched, taking new values only while disabled
// - mode set makes the pass device fully on or off by the enable state
// - passive discharge on entering off or hard reset, when set also while disabled
// - pin-controlled linreg1 follows the OR of pins selected in its own mask
`ifndef REC_DEFS_SVH
`define REC_DEFS_SVH

`define REC_ADDR_BOOST_MASK 8'h59
`define REC_ADDR_LR1_ENA 8'h5A
`define REC_ADDR_LR1_CFG 8'h5B

`define REC_RST_BOOST_MASK 8'h08
`define REC_RST_LR1_ENA 8'h00
`define REC_RST_LR1_CFG 8'h01

`define REC_LR1_ENA_WMASK 8'hE3
`define REC_LR1_CFG_WMASK 8'h0F

`define REC_SEQ_MSB 7
`define REC_SEQ_LSB 5
`define REC_EN_MSB 1
`define REC_EN_LSB 0
`define REC_CFG_INTSUP 3
`define REC_CFG_ACTDSC 2
`define REC_CFG_MODE 1
`define REC_CFG_PSVDSC 0

`define REC_PIN_COUNT 8
`define REC_SYNC_STAGES 2

`endif

// ---- rec_pkg.sv ----
// types shared by the regulator enable block
package rec_pkg;

    typedef enum logic [2:0] {
        REC_SEQ_OFF = 3'h0,
        REC_SEQ_SUPPLY = 3'h1,
        REC_SEQ_BOOT0 = 3'h2,
        REC_SEQ_BOOT25 = 3'h3,
        REC_SEQ_BOOT50 = 3'h4,
        REC_SEQ_RSVD5 = 3'h5,
        REC_SEQ_RSVD6 = 3'h6,
        REC_SEQ_FIELD = 3'h7
    } rec_seq_type;

    typedef enum logic [1:0] {
        REC_EN_OFF = 2'h0,
        REC_EN_ON = 2'h1,
        REC_EN_PINS = 2'h2,
        REC_EN_RSVD = 2'h3
    } rec_en_type;

endpackage : rec_pkg

// ---- rec_sync_if.sv ----
// carrier between the pin synchronizer and the enable logic
`timescale 1ns/1ns
`default_nettype none
interface rec_sync_if;
    logic [7:0] raw_pins;
    logic raw_supply;
    logic [7:0] pins;
    logic supply;

    modport syncer (
        input raw_pins,
        input raw_supply,
        output pins,
        output supply
    );

    modport user (
        output raw_pins,
        output raw_supply,
        input pins,
        input supply
    );
endinterface : rec_sync_if
`default_nettype wire

// ---- rec_pin_sync.sv ----
// two-stage synchronizer for the control pins and the supply-present level
`timescale 1ns/1ns
`default_nettype none
module rec_pin_sync
    import rec_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // pins in, synchronized levels out
    rec_sync_if.syncer sync
);
    `include "rec_defs.svh"

    logic [8:0] stage1_reg;
    logic [8:0] stage2_reg;

    // stage1 is read only by stage2, nothing else may look at it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= 9'h000;
            stage2_reg <= 9'h000;
        end else begin
            stage1_reg <= {sync.raw_supply, sync.raw_pins};
            stage2_reg <= stage1_reg;
        end
    end

    assign sync.pins = stage2_reg[7:0];
    assign sync.supply = stage2_reg[8];

    // checked against the pin itself, so the first stage stays private to the second
    sync_delay_a: assert property (@(posedge mclk) disable iff (!nrst)
        $past(nrst, 2) |-> stage2_reg == $past({sync.raw_supply, sync.raw_pins}, 2))
        else $error("synchronizer not two cycles behind the pin");
endmodule : rec_pin_sync
`default_nettype wire

// ---- regulator_enable_control.sv ----
// enable, discharge and mode control for the buck-boost and linear regulator 1
`timescale 1ns/1ns
`default_nettype none
module regulator_enable_control
    import rec_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // register access port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // pins from outside
    input wire logic [7:0] multipurpose_control_pin,
    input wire logic supply_present_pin,
    // buck-boost fields held elsewhere
    input wire logic [2:0] boost_sequence_field,
    input wire logic [1:0] boost_enable_field,
    // linreg1 pin mask held elsewhere
    input wire logic [7:0] linreg1_pin_select_mask,
    // boot sequencer and power state
    input wire logic boot_point_0,
    input wire logic boot_point_25,
    input wire logic boot_point_50,
    input wire logic boot_point_100,
    input wire logic hard_reset_mode,
    input wire logic off_entry,
    // regulator controls
    output logic boost_pin_enable,
    output logic boost_pin_mode,
    output logic linreg1_enable,
    output logic linreg1_pass_full_on,
    output logic linreg1_internal_supply,
    output logic linreg1_switch_mode,
    output logic linreg1_active_discharge,
    output logic linreg1_passive_discharge
);
    `include "rec_defs.svh"

    rec_sync_if sync ();

    assign sync.raw_pins = multipurpose_control_pin;
    assign sync.raw_supply = supply_present_pin;

    rec_pin_sync u_rec_pin_sync (
        .mclk (mclk),
        .nrst (nrst),
        .sync (sync)
    );

    // register file
    logic [7:0] boost_pin_select_mask_reg;
    logic [7:0] linreg1_enable_config_reg;
    logic [7:0] linreg1_misc_config_reg;
    logic [7:0] reg_rdata_reg;
    logic reg_rvalid_reg;

    wire hit_boost = reg_addr == `REC_ADDR_BOOST_MASK;
    wire hit_ena = reg_addr == `REC_ADDR_LR1_ENA;
    wire hit_cfg = reg_addr == `REC_ADDR_LR1_CFG;
    wire wr_boost = reg_wr && hit_boost;
    wire wr_ena = reg_wr && hit_ena;
    wire wr_cfg = reg_wr && hit_cfg;

    // reserved bits are never stored, so they read back as zero
    wire [7:0] ena_wdata = reg_wdata & `REC_LR1_ENA_WMASK;
    wire [7:0] cfg_wdata = reg_wdata & `REC_LR1_CFG_WMASK;

    wire [7:0] read_mux = hit_boost ? boost_pin_select_mask_reg :
                          hit_ena ? linreg1_enable_config_reg :
                          hit_cfg ? linreg1_misc_config_reg : 8'h00;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            boost_pin_select_mask_reg <= `REC_RST_BOOST_MASK;
            linreg1_enable_config_reg <= `REC_RST_LR1_ENA;
            linreg1_misc_config_reg <= `REC_RST_LR1_CFG;
        end else begin
            if (wr_boost) begin
                boost_pin_select_mask_reg <= reg_wdata;
            end
            if (wr_ena) begin
                linreg1_enable_config_reg <= ena_wdata;
            end
            if (wr_cfg) begin
                linreg1_misc_config_reg <= cfg_wdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_reg <= 8'h00;
            reg_rvalid_reg <= 1'b0;
        end else begin
            reg_rdata_reg <= reg_rd ? read_mux : reg_rdata_reg;
            reg_rvalid_reg <= reg_rd;
        end
    end

    assign reg_rdata = reg_rdata_reg;
    assign reg_rvalid = reg_rvalid_reg;

    // field views
    rec_seq_type lr1_seq;
    rec_en_type lr1_en;
    assign lr1_seq = rec_seq_type'(linreg1_enable_config_reg[`REC_SEQ_MSB:`REC_SEQ_LSB]);
    assign lr1_en = rec_en_type'(linreg1_enable_config_reg[`REC_EN_MSB:`REC_EN_LSB]);

    wire cfg_intsup = linreg1_misc_config_reg[`REC_CFG_INTSUP];
    wire cfg_actdsc = linreg1_misc_config_reg[`REC_CFG_ACTDSC];
    wire cfg_mode = linreg1_misc_config_reg[`REC_CFG_MODE];
    wire cfg_psvdsc = linreg1_misc_config_reg[`REC_CFG_PSVDSC];

    // buck-boost pin path
    wire boost_mode_now = boost_sequence_field == 3'h7 && boost_enable_field == 2'h2;
    wire [7:0] boost_sel_pins = boost_pin_select_mask_reg & sync.pins;
    wire boost_or = |boost_sel_pins;
    wire boost_next = boost_mode_now && boost_or;

    // linreg1 enable field decode, reserved code keeps the regulator off
    wire lr1_pin_mode = lr1_seq == REC_SEQ_FIELD && lr1_en == REC_EN_PINS;
    wire lr1_pin_or = |(linreg1_pin_select_mask & sync.pins);
    logic lr1_field_on;
    always_comb begin
        lr1_field_on = 1'b0;
        unique case (lr1_en)
            REC_EN_OFF: lr1_field_on = 1'b0;
            REC_EN_ON: lr1_field_on = 1'b1;
            REC_EN_PINS: lr1_field_on = lr1_pin_or;
            REC_EN_RSVD: lr1_field_on = 1'b0;
        endcase
    end

    // sequence decode; boot points are levels read each cycle, so linreg1 turns off again if its point drops
    logic lr1_next;
    always_comb begin
        lr1_next = 1'b0;
        unique case (lr1_seq)
            REC_SEQ_OFF: lr1_next = 1'b0;
            REC_SEQ_SUPPLY: lr1_next = sync.supply;
            REC_SEQ_BOOT0: lr1_next = boot_point_0;
            REC_SEQ_BOOT25: lr1_next = boot_point_25;
            REC_SEQ_BOOT50: lr1_next = boot_point_50;
            REC_SEQ_RSVD5: lr1_next = 1'b0;
            REC_SEQ_RSVD6: lr1_next = 1'b0;
            REC_SEQ_FIELD: lr1_next = boot_point_100 && lr1_field_on;
        endcase
    end

    // enables, mode latch and discharge state
    logic boost_enable_reg;
    logic lr1_enable_reg;
    logic mode_latch_reg;
    logic dsc_armed_reg;
    logic active_dsc_reg;
    logic passive_dsc_reg;

    wire lr1_fall = lr1_enable_reg && !lr1_next;
    wire lr1_rise = !lr1_enable_reg && lr1_next;
    // armed only by a real falling edge, so a regulator never turned on is not loaded
    wire dsc_armed_next = lr1_fall ? 1'b1 : (lr1_rise ? 1'b0 : dsc_armed_reg);
    wire active_dsc_next = hard_reset_mode || (cfg_actdsc && !lr1_next && dsc_armed_next);
    wire passive_dsc_next = hard_reset_mode || off_entry || (cfg_psvdsc && !lr1_next);
    // the latch follows the register only while the regulator is off
    wire mode_latch_next = lr1_enable_reg ? mode_latch_reg : cfg_mode;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            boost_enable_reg <= 1'b0;
            lr1_enable_reg <= 1'b0;
            mode_latch_reg <= 1'b0;
            dsc_armed_reg <= 1'b0;
            active_dsc_reg <= 1'b0;
            passive_dsc_reg <= 1'b0;
        end else begin
            boost_enable_reg <= boost_next;
            lr1_enable_reg <= lr1_next;
            mode_latch_reg <= mode_latch_next;
            dsc_armed_reg <= dsc_armed_next;
            active_dsc_reg <= active_dsc_next;
            passive_dsc_reg <= passive_dsc_next;
        end
    end

    assign boost_pin_enable = boost_enable_reg;
    assign boost_pin_mode = boost_mode_now;
    assign linreg1_enable = lr1_enable_reg;
    assign linreg1_switch_mode = mode_latch_reg;
    assign linreg1_pass_full_on = mode_latch_reg && lr1_enable_reg;
    assign linreg1_internal_supply = cfg_intsup;
    assign linreg1_active_discharge = active_dsc_reg;
    assign linreg1_passive_discharge = passive_dsc_reg;

    // checks
    logic first_cycle_reg;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            first_cycle_reg <= 1'b1;
        end else begin
            first_cycle_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    boost_reset_a: assert property (first_cycle_reg && !$past(wr_boost)
        |-> boost_pin_select_mask_reg == `REC_RST_BOOST_MASK)
        else $error("boost mask reset value wrong");

    boost_pins_a: assert property ((boost_mode_now && !wr_boost
        && $stable(multipurpose_control_pin))[*4]
        |-> boost_pin_enable == |(boost_pin_select_mask_reg & multipurpose_control_pin))
        else $error("buck-boost not OR of selected pins");

    boost_ignore_a: assert property (!boost_mode_now |=> !boost_pin_enable)
        else $error("boost pins acted outside pin mode");

    lr1_off_a: assert property (lr1_seq == REC_SEQ_OFF |=> !linreg1_enable)
        else $error("linreg1 on with sequence off");

    lr1_supply_a: assert property ((lr1_seq == REC_SEQ_SUPPLY && !wr_ena
        && $stable(supply_present_pin))[*4]
        |-> linreg1_enable == supply_present_pin)
        else $error("linreg1 not following supply present");

    lr1_boot_a: assert property (lr1_seq == REC_SEQ_BOOT25
        |=> linreg1_enable == $past(boot_point_25))
        else $error("linreg1 not on at quarter boot");

    lr1_boot0_a: assert property (lr1_seq == REC_SEQ_BOOT0
        |=> linreg1_enable == $past(boot_point_0))
        else $error("linreg1 not on at boot start");

    lr1_boot50_a: assert property (lr1_seq == REC_SEQ_BOOT50
        |=> linreg1_enable == $past(boot_point_50))
        else $error("linreg1 not on at half boot");

    lr1_rsvd_a: assert property (lr1_seq inside {REC_SEQ_RSVD5, REC_SEQ_RSVD6}
        || (lr1_seq == REC_SEQ_FIELD && !boot_point_100) |=> !linreg1_enable)
        else $error("linreg1 on under reserved code or before boot end");

    lr1_field_a: assert property (lr1_seq == REC_SEQ_FIELD && boot_point_100
        && lr1_en == REC_EN_ON ##1 lr1_seq == REC_SEQ_FIELD |-> linreg1_enable)
        else $error("enable field 01 did not turn linreg1 on");

    lr1_field_off_a: assert property (lr1_seq == REC_SEQ_FIELD
        && lr1_en inside {REC_EN_OFF, REC_EN_RSVD} |=> !linreg1_enable)
        else $error("enable field 00 or 11 left linreg1 on");

    lr1_pins_a: assert property ((lr1_pin_mode && boot_point_100 && !wr_ena
        && $stable(multipurpose_control_pin) && $stable(linreg1_pin_select_mask))[*4]
        |-> linreg1_enable == |(linreg1_pin_select_mask & multipurpose_control_pin))
        else $error("linreg1 not OR of its selected pins");

    mode_hold_a: assert property (linreg1_enable |=> $stable(linreg1_switch_mode))
        else $error("mode latch moved while regulator on");

    mode_take_a: assert property (!linreg1_enable
        |=> linreg1_switch_mode == $past(cfg_mode))
        else $error("mode latch missed a value while regulator off");

    full_on_a: assert property (linreg1_pass_full_on
        |-> linreg1_enable && linreg1_switch_mode)
        else $error("pass device full on without enable and mode");

    full_off_a: assert property (!linreg1_enable |-> !linreg1_pass_full_on)
        else $error("pass device full on while regulator off");

    act_dsc_a: assert property ((hard_reset_mode |=> linreg1_active_discharge)
        and (cfg_actdsc && $fell(linreg1_enable) && !hard_reset_mode
        ##1 !linreg1_enable |-> linreg1_active_discharge))
        else $error("active discharge missing");

    act_quiet_a: assert property (!hard_reset_mode && !cfg_actdsc
        |=> !linreg1_active_discharge)
        else $error("active discharge without cause");

    psv_dsc_a: assert property (hard_reset_mode || off_entry || (cfg_psvdsc && !lr1_next)
        |=> linreg1_passive_discharge)
        else $error("passive discharge missing");

    psv_quiet_a: assert property (!hard_reset_mode && !off_entry && !cfg_psvdsc
        |=> !linreg1_passive_discharge)
        else $error("passive discharge without cause");

    // register port: reserved bits never stored, read answer one cycle behind the strobe
    rsvd_bits_a: assert property ((linreg1_enable_config_reg & ~`REC_LR1_ENA_WMASK) == 8'h00
        && (linreg1_misc_config_reg & ~`REC_LR1_CFG_WMASK) == 8'h00)
        else $error("reserved register bits stored");

    read_valid_a: assert property (reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after read strobe");

    read_unmapped_a: assert property (reg_rd && !hit_boost && !hit_ena && !hit_cfg
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : regulator_enable_control
`default_nettype wire

// ---- rec_far_side.sv ----
// far-side model: external pin driver and boot sequencer feeding the block
`timescale 1ns/1ns
`default_nettype none
module rec_far_side (
    // requested levels
    input wire logic [7:0] want_pins,
    input wire logic want_supply,
    input wire logic [2:0] boot_stage,
    // driven levels
    output logic [7:0] pins,
    output logic supply,
    output logic [3:0] boot_points
);
    // push-pull pins, so a level is held until changed; no pull to fall back on
    assign pins = want_pins;
    assign supply = want_supply;
    // boot points rise in order with boot_stage and drop again whenever boot_stage is lowered
    assign boot_points = 4'((5'h01 << boot_stage) - 5'h01);
endmodule : rec_far_side
`default_nettype wire

// ---- test_regulator_enable_control.sv ----
// self-checking bench for the regulator enable block
`timescale 1ns/1ns
`default_nettype none
module test_regulator_enable_control
    import rec_pkg::*;
;
    logic mclk, nrst, reg_wr, reg_rd, reg_rvalid, supply_present_pin, hard_reset_mode, off_entry;
    logic want_supply, boost_pin_enable, boost_pin_mode, linreg1_enable, linreg1_pass_full_on;
    logic linreg1_internal_supply, linreg1_switch_mode, linreg1_active_discharge, lr1_psv;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, mpc_pins, want_pins, lr1_mask;
    logic [2:0] boost_seq, boot_stage;
    logic [1:0] boost_en;
    logic [3:0] boot_points;
    logic [7:0] read_q[$];
    int n_mismatch = 0;
    int samples_checked = 0;

    regulator_enable_control u_regulator_enable_control (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .multipurpose_control_pin(mpc_pins), .supply_present_pin(supply_present_pin),
        .boost_sequence_field(boost_seq), .boost_enable_field(boost_en),
        .linreg1_pin_select_mask(lr1_mask), .boot_point_0(boot_points[0]),
        .boot_point_25(boot_points[1]), .boot_point_50(boot_points[2]),
        .boot_point_100(boot_points[3]), .hard_reset_mode(hard_reset_mode),
        .off_entry(off_entry), .boost_pin_enable(boost_pin_enable),
        .boost_pin_mode(boost_pin_mode), .linreg1_enable(linreg1_enable),
        .linreg1_pass_full_on(linreg1_pass_full_on),
        .linreg1_internal_supply(linreg1_internal_supply),
        .linreg1_switch_mode(linreg1_switch_mode),
        .linreg1_active_discharge(linreg1_active_discharge),
        .linreg1_passive_discharge(lr1_psv)
    );

    rec_far_side u_rec_far_side (
        .want_pins(want_pins), .want_supply(want_supply), .boot_stage(boot_stage),
        .pins(mpc_pins), .supply(supply_present_pin), .boot_points(boot_points)
    );

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    task automatic chk_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    // strobe low for a cycle after each access so no signal is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
        step(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        read_q.push_back(exp);
        reg_addr = a;
        reg_rd = 1'b1;
        step(1);
        reg_rd = 1'b0;
        step(1);
    endtask : rd

    function automatic logic lr1_exp(input logic [2:0] s, input logic [1:0] e,
                                     input logic [3:0] bp, input logic sup,
                                     input logic [7:0] m, input logic [7:0] p);
        case (s)
            REC_SEQ_SUPPLY: return sup;
            REC_SEQ_BOOT0: return bp[0];
            REC_SEQ_BOOT25: return bp[1];
            REC_SEQ_BOOT50: return bp[2];
            REC_SEQ_FIELD: return bp[3] && (e == REC_EN_ON || (e == REC_EN_PINS && |(m & p)));
            default: return 1'b0;
        endcase
    endfunction : lr1_exp

    task automatic results();
        if (read_q.size() != 0) begin
            n_mismatch++;
            $display("mismatch read data expected %0d more seen none", read_q.size());
        end
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    always @(posedge mclk) begin
        if (reg_rvalid === 1'b1) begin
            if (read_q.size() == 0) begin
                n_mismatch++;
                $display("mismatch read data expected none seen %h", reg_rdata);
            end else begin
                chk_byte("read data", read_q.pop_front(), reg_rdata);
            end
        end
    end

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // the tests need about six hundred cycles; allow about forty times that
    initial begin
        #200000;
        n_mismatch++;
        $display("mismatch watchdog expected finish seen timeout");
        results();
    end

    initial begin
        logic [7:0] m, p;
        logic lr1_want;
        nrst = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, want_pins, want_supply} = '0;
        {boost_seq, boost_en, lr1_mask, boot_stage, hard_reset_mode, off_entry} = '0;
        void'($urandom(92107));
        repeat (8) @(posedge mclk);
        #1;
        nrst = 1'b1;
        step(1);
        rd(8'h59, 8'h08);
        rd(8'h5A, 8'h00);
        rd(8'h5B, 8'h01);
        rd(8'h5C, 8'h00);
        wr(8'h5A, 8'hFF);
        rd(8'h5A, 8'hE3);
        wr(8'h5B, 8'hFF);
        rd(8'h5B, 8'h0F);
        chk_bit("internal supply", 1'b1, linreg1_internal_supply);
        wr(8'h5B, 8'h01);
        chk_bit("internal supply", 1'b0, linreg1_internal_supply);
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            m = 8'($urandom);
            p = 8'($urandom);
            boost_seq = (i % 3 != 0) ? 3'h7 : 3'($urandom);
            boost_en = (i % 3 != 2) ? 2'h2 : 2'($urandom);
            wr(8'h59, m);
            rd(8'h59, m);
            want_pins = p;
            step(4);
            chk_bit("boost mode", boost_seq == 3'h7 && boost_en == 2'h2, boost_pin_mode);
            chk_bit("boost enable", boost_seq == 3'h7 && boost_en == 2'h2 && |(m & p), boost_pin_enable);
        end
        boost_seq = 3'h7;
        boost_en = 2'h2;
        wr(8'h59, 8'h08);
        want_pins = 8'hF7;
        step(4);
        chk_bit("boost enable", 1'b0, boost_pin_enable);
        want_pins = 8'h08;
        step(2);
        chk_bit("boost enable early", 1'b0, boost_pin_enable);
        step(1);
        chk_bit("boost enable", 1'b1, boost_pin_enable);
        $display("test boost pins done");
        for (int si = 0; si < 8; si++) begin
            for (int ei = 0; ei < 8; ei++) begin
                boot_stage = (ei > 3) ? 3'h4 : 3'($urandom_range(3));
                want_supply = 1'($urandom);
                lr1_mask = 8'($urandom);
                want_pins = 8'($urandom);
                wr(8'h5A, {3'(si), 3'h0, 2'(ei)});
                step(3);
                lr1_want = lr1_exp(3'(si), 2'(ei), boot_points, want_supply, lr1_mask, want_pins);
                chk_bit("linreg1 enable", lr1_want, linreg1_enable);
            end
        end
        $display("test linreg1 sequence done");
        want_supply = 1'b1;
        wr(8'h5A, 8'h20);
        step(3);
        chk_bit("linreg1 enable", 1'b1, linreg1_enable);
        chk_bit("passive discharge", 1'b0, lr1_psv);
        wr(8'h5B, 8'h07);
        step(2);
        chk_bit("switch mode", 1'b0, linreg1_switch_mode);
        chk_bit("pass full on", 1'b0, linreg1_pass_full_on);
        wr(8'h5A, 8'h00);
        step(3);
        chk_bit("switch mode", 1'b1, linreg1_switch_mode);
        chk_bit("active discharge", 1'b1, linreg1_active_discharge);
        chk_bit("passive discharge", 1'b1, lr1_psv);
        wr(8'h5A, 8'h20);
        step(3);
        chk_bit("pass full on", 1'b1, linreg1_pass_full_on);
        chk_bit("active discharge", 1'b0, linreg1_active_discharge);
        wr(8'h5B, 8'h00);
        step(2);
        chk_bit("switch mode", 1'b1, linreg1_switch_mode);
        wr(8'h5A, 8'h00);
        step(3);
        chk_bit("switch mode", 1'b0, linreg1_switch_mode);
        chk_bit("active discharge", 1'b0, linreg1_active_discharge);
        chk_bit("passive discharge", 1'b0, lr1_psv);
        hard_reset_mode = 1'b1;
        step(2);
        chk_bit("active discharge", 1'b1, linreg1_active_discharge);
        chk_bit("passive discharge", 1'b1, lr1_psv);
        hard_reset_mode = 1'b0;
        off_entry = 1'b1;
        step(2);
        chk_bit("passive discharge", 1'b1, lr1_psv);
        chk_bit("active discharge", 1'b0, linreg1_active_discharge);
        off_entry = 1'b0;
        $display("test mode and discharge done");
        // the mask is moved off its reset value first, so the reread proves the reset
        wr(8'h59, 8'hA5);
        nrst = 1'b0;
        step(2);
        nrst = 1'b1;
        step(1);
        rd(8'h59, 8'h08);
        rd(8'h5B, 8'h01);
        chk_bit("passive discharge", 1'b1, lr1_psv);
        $display("test mid-run reset done");
        results();
    end
endmodule : test_regulator_enable_control
`default_nettype wire
